// ==== qs_pkg.sv ====
// Shared constants and carrier types for the multi-queue flag and status block.
package qs_pkg;

  // ******************************************************************
  // Sizes
  // ******************************************************************
  localparam int NUM_Q  = 8;
  localparam int QW     = 3;
  localparam int DEV_W  = 3;
  localparam int DATA_W = 36;
  localparam int TMR_W  = 3;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS           = 40;
  localparam int WRITE_TO_READ_SKEW_NS   = 40;
  localparam int SELECT_TO_FLAG_SKEW_NS  = 40;
  localparam int WR_SKEW_CYC = (WRITE_TO_READ_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_SKEW_CYC = (SELECT_TO_FLAG_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [TMR_W-1:0] FLAG_ASSERT_LAT   = 3'h2;
  localparam logic [TMR_W-1:0] FLAG_DEASSERT_LAT = TMR_W'(WR_SKEW_CYC + 1);
  localparam logic [TMR_W-1:0] SELECT_DEASSERT_LAT = TMR_W'(SEL_SKEW_CYC + 1);
  localparam logic [1:0]       FIRST_WORD_FALL_THROUGH_LAT          = 2'h2;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic AE_STATUS_RESET = 1'b0;
  localparam logic AF_STATUS_RESET = 1'b1;
  localparam logic EXPAND_OUT_IDLE = 1'b1;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic             valid;
    logic [DEV_W-1:0] device;
    logic [QW-1:0]    queue;
  } qs_select_t;

  typedef struct packed {
    logic             valid;
    logic [DEV_W-1:0] device;
  } qs_owner_t;

endpackage

// ==== qs_bus_drive.sv ====
// Registered value and drive enable for one shared, tri-stated flag output group.
`timescale 1ns/1ps
module qs_bus_drive #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] next_value,
  input  wire logic         next_drive,
  input  wire logic [W-1:0] reset_value,
  output logic      [W-1:0] value,
  output logic              drive
);
  import qs_pkg::*;

  // ******************************************************************
  // Output register
  // ******************************************************************
  // The enable is a flop of its own so a handover never overlaps drivers.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      value <= '1;
      drive <= 1'b0;
    end else begin
      value <= next_drive ? next_value : reset_value;
      drive <= next_drive;
    end
  end

endmodule

// ==== qs_queue_state.sv ====
// Occupancy, pointers and delayed almost-empty/almost-full status of one queue.
`timescale 1ns/1ps
module qs_queue_state #(
  parameter int DEPTH    = 16,
  parameter int AE_LEVEL = 2,
  parameter int AF_LEVEL = 2,
  parameter int AW       = $clog2(DEPTH)
) (
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic          ae_skew_late,
  input  wire logic          af_skew_late,
  input  wire logic          af_deassert_select,
  output logic      [AW-1:0] wr_ptr,
  output logic      [AW-1:0] rd_ptr,
  output logic               empty,
  output logic               full,
  output logic               ae_status_n,
  output logic               af_status_n
);
  import qs_pkg::*;

  logic [AW:0]        count;
  logic [AW:0]        next_count;
  logic [AW-1:0]      next_wr_ptr;
  logic [AW-1:0]      next_rd_ptr;
  logic [TMR_W-1:0]   ae_tmr;
  logic [TMR_W-1:0]   af_tmr;
  logic [TMR_W:0]     ae_step;
  logic [TMR_W:0]     af_step;
  logic               ae_raw_n;
  logic               af_raw_n;
  logic [TMR_W-1:0]   ae_up_lat;
  logic [TMR_W-1:0]   af_up_lat;

  // ******************************************************************
  // Flag delay
  // ******************************************************************
  // A new raw level must persist for the whole latency; a bounce restarts it.
  function automatic logic [TMR_W:0] flag_step(input logic raw, input logic stat,
                                               input logic [TMR_W-1:0] tmr,
                                               input logic [TMR_W-1:0] lat);
    logic [TMR_W:0] r;
    r = {stat, {TMR_W{1'b0}}};
    if (raw != stat) begin
      if (tmr == '0) begin
        if (lat <= FLAG_ASSERT_LAT) begin
          r = {raw, {TMR_W{1'b0}}};
        end else begin
          r = {stat, TMR_W'(lat - FLAG_ASSERT_LAT)};
        end
      end else if (tmr == TMR_W'(1)) begin
        r = {raw, {TMR_W{1'b0}}};
      end else begin
        r = {stat, TMR_W'(tmr - TMR_W'(1))};
      end
    end
    return r;
  endfunction

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    empty       = (count == '0);
    full        = (count == (AW+1)'(DEPTH));
    next_count  = count;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push && !full) begin
      next_wr_ptr = AW'(wr_ptr + AW'(1));
    end
    if (pop && !empty) begin
      next_rd_ptr = AW'(rd_ptr + AW'(1));
    end
    next_count = (AW+1)'(count + (AW+1)'(push && !full) - (AW+1)'(pop && !empty));
    ae_raw_n   = (count > (AW+1)'(AE_LEVEL));
    af_raw_n   = (count < (AW+1)'(DEPTH - AF_LEVEL));
    ae_up_lat  = TMR_W'(FLAG_DEASSERT_LAT + TMR_W'(ae_skew_late)); // [R1] [R2] [R3]
    af_up_lat  = TMR_W'((af_deassert_select ? SELECT_DEASSERT_LAT : FLAG_DEASSERT_LAT)
                        + TMR_W'(af_skew_late)); // [R9]
    ae_step    = flag_step(ae_raw_n, ae_status_n, ae_tmr,
                           ae_raw_n ? ae_up_lat : FLAG_ASSERT_LAT); // [R1] [R8]
    af_step    = flag_step(af_raw_n, af_status_n, af_tmr,
                           af_raw_n ? af_up_lat : FLAG_ASSERT_LAT); // [R19] [R12]
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count       <= '0;
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      ae_status_n <= AE_STATUS_RESET;
      af_status_n <= AF_STATUS_RESET;
      ae_tmr      <= '0;
      af_tmr      <= '0;
    end else begin
      count       <= next_count;
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      ae_status_n <= ae_step[TMR_W];
      af_status_n <= af_step[TMR_W];
      ae_tmr      <= ae_step[TMR_W-1:0];
      af_tmr      <= af_step[TMR_W-1:0];
    end
  end

endmodule

// ==== qs_multiqueue_flags.sv ====
// Multi-queue store with almost-empty/almost-full flags, status buses and expansion.
//
// Contract
// [R1] Empty flag: low after 2, high after skew+1.
// [R2] Missed write-to-read skew adds one cycle.
// [R3] Write to read queue raises flag likewise.
// [R4] Empty status bus follows selection one cycle later.
// [R5] New empty-bus owner drives; old owner releases.
// [R6] Status bus bit index equals queue index.
// [R7] Unselected device floats its discrete empty flag.
// [R8] Read to almost empty drives bit, flag low.
// [R9] Read off almost full raises bit after skew.
// [R10] Full status bus follows last cycle's selection.
// [R11] Host picks full-bus owner via write port.
// [R12] Write to almost full drives bit, flag low.
// [R13] Write-selected device drives discrete full flag.
// [R14] Board ties master expansion inputs low.
// [R15] Data bits connect same-to-same across devices.
// [R16] New read queue falls through without read enable.
// [R17] Output enable low drives last output word.
// [R18] Read enable high blocks reads except fall-through.
// [R19] Full flag goes low two cycles after write.
// [R20] All flags and status bits are active low.
`timescale 1ns/1ps
module qs_multiqueue_flags #(
  parameter int               DEPTH     = 16,
  parameter int               AE_LEVEL  = 2,
  parameter int               AF_LEVEL  = 2,
  parameter logic [qs_pkg::DEV_W-1:0] DEVICE_ID = 3'h0
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       write_en_n,
  input  wire logic [qs_pkg::DATA_W-1:0]  write_data,
  input  wire qs_pkg::qs_select_t         write_sel,
  input  wire logic                       read_en_n,
  input  wire qs_pkg::qs_select_t         read_sel,
  input  wire qs_pkg::qs_owner_t          ae_bus_sel,
  input  wire qs_pkg::qs_owner_t          af_bus_sel,
  input  wire logic                       output_enable_n,
  input  wire logic                       ae_skew_late,
  input  wire logic                       af_skew_late,
  input  wire logic                       full_expand_in,
  input  wire logic                       empty_expand_in,
  output logic      [qs_pkg::DATA_W-1:0]  data_out,
  output logic                            data_out_oe,
  output logic                            almost_empty_flag,
  output logic                            almost_empty_flag_oe,
  output logic                            almost_full_flag,
  output logic                            almost_full_flag_oe,
  output logic      [qs_pkg::NUM_Q-1:0]   almost_empty_status_bus,
  output logic                            almost_empty_status_bus_oe,
  output logic      [qs_pkg::NUM_Q-1:0]   almost_full_status_bus,
  output logic                            almost_full_status_bus_oe,
  output logic                            full_expand_out,
  output logic                            empty_expand_out
);
  import qs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ******************************************************************
  // Storage and per-queue state
  // ******************************************************************
  logic [DATA_W-1:0] mem [NUM_Q*DEPTH];
  logic [AW-1:0]     wr_ptr [NUM_Q];
  logic [AW-1:0]     rd_ptr [NUM_Q];
  logic [NUM_Q-1:0]  q_empty;
  logic [NUM_Q-1:0]  q_full;
  logic [NUM_Q-1:0]  ae_status_n;
  logic [NUM_Q-1:0]  af_status_n;
  logic [NUM_Q-1:0]  push_q;
  logic [NUM_Q-1:0]  pop_q;

  // ******************************************************************
  // Port selection state
  // ******************************************************************
  logic [QW-1:0]     wr_q;
  logic              wr_owned;
  logic [QW-1:0]     rd_q;
  logic              rd_owned;
  logic [1:0]        fall_cnt;
  logic              ae_own;
  logic              af_own;
  logic              strap_taken;
  logic              af_sel_recent;
  logic [QW-1:0]     next_wr_q;
  logic              next_wr_owned;
  logic [QW-1:0]     next_rd_q;
  logic              next_rd_owned;
  logic [1:0]        next_fall_cnt;
  logic              next_ae_own;
  logic              next_af_own;
  logic              next_strap_taken;
  logic              next_af_sel_recent;
  logic              push;
  logic              pop;
  logic              fall_through;

  // ******************************************************************
  // Output registers
  // ******************************************************************
  logic [DATA_W-1:0] next_data_out;
  logic              next_data_out_oe;

  // ******************************************************************
  // Queues
  // ******************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_Q; gi++) begin : g_queue
      assign push_q[gi] = push && (wr_q == QW'(gi));
      assign pop_q[gi]  = pop && (rd_q == QW'(gi));
      qs_queue_state #(
        .DEPTH    (DEPTH),
        .AE_LEVEL (AE_LEVEL),
        .AF_LEVEL (AF_LEVEL)
      ) u_state (
        .ref_clk            (ref_clk),
        .reset_n            (reset_n),
        .push               (push_q[gi]),
        .pop                (pop_q[gi]),
        .ae_skew_late       (ae_skew_late),
        .af_skew_late       (af_skew_late),
        .af_deassert_select (af_sel_recent),
        .wr_ptr             (wr_ptr[gi]),
        .rd_ptr             (rd_ptr[gi]),
        .empty              (q_empty[gi]),
        .full               (q_full[gi]),
        .ae_status_n        (ae_status_n[gi]),
        .af_status_n        (af_status_n[gi])
      );
    end
  endgenerate

  // ******************************************************************
  // Selection and transfer control
  // ******************************************************************
  always_comb begin
    next_wr_q          = wr_q;
    next_wr_owned      = wr_owned;
    next_rd_q          = rd_q;
    next_rd_owned      = rd_owned;
    next_fall_cnt      = (fall_cnt != '0) ? 2'(fall_cnt - 2'h1) : fall_cnt;
    next_ae_own        = ae_own;
    next_af_own        = af_own;
    next_strap_taken   = 1'b1;
    next_af_sel_recent = 1'b0;
    if (write_sel.valid) begin
      next_wr_q     = write_sel.queue;
      next_wr_owned = (write_sel.device == DEVICE_ID); // [R13]
    end
    if (read_sel.valid) begin
      next_rd_q     = read_sel.queue;
      next_rd_owned = (read_sel.device == DEVICE_ID); // [R7]
      next_fall_cnt = FIRST_WORD_FALL_THROUGH_LAT; // [R16]
    end
    // Direct mode strap: only a master starts out owning both status buses.
    if (!strap_taken) begin
      next_ae_own = !empty_expand_in; // [R14]
      next_af_own = !full_expand_in; // [R14]
    end
    if (ae_bus_sel.valid) begin
      next_ae_own = (ae_bus_sel.device == DEVICE_ID); // [R4] [R5]
    end
    if (af_bus_sel.valid) begin
      next_af_own        = (af_bus_sel.device == DEVICE_ID); // [R10] [R11]
      next_af_sel_recent = 1'b1;
    end
    push         = !write_en_n && wr_owned && !q_full[wr_q];
    // Fall-through ignores the read enable; normal reads wait for it.
    fall_through = (fall_cnt == 2'h1) && rd_owned && !q_empty[rd_q]; // [R16]
    pop          = fall_through
                 || (!read_en_n && (fall_cnt == '0) && rd_owned && !q_empty[rd_q]); // [R18]
    next_data_out    = pop ? mem[{rd_q, rd_ptr[rd_q]}] : data_out; // [R17]
    next_data_out_oe = !output_enable_n && rd_owned; // [R17]
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_q          <= '0;
      wr_owned      <= 1'b0;
      rd_q          <= '0;
      rd_owned      <= 1'b0;
      fall_cnt      <= '0;
      ae_own        <= 1'b0;
      af_own        <= 1'b0;
      strap_taken   <= 1'b0;
      af_sel_recent <= 1'b0;
      data_out      <= '0;
      data_out_oe   <= 1'b0;
    end else begin
      wr_q          <= next_wr_q;
      wr_owned      <= next_wr_owned;
      rd_q          <= next_rd_q;
      rd_owned      <= next_rd_owned;
      fall_cnt      <= next_fall_cnt;
      ae_own        <= next_ae_own;
      af_own        <= next_af_own;
      strap_taken   <= next_strap_taken;
      af_sel_recent <= next_af_sel_recent;
      data_out      <= next_data_out;
      data_out_oe   <= next_data_out_oe;
    end
  end

  // Memory has no reset; contents are only seen after a write.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[{wr_q, wr_ptr[wr_q]}] <= write_data;
    end
  end

  // ******************************************************************
  // Flag outputs
  // ******************************************************************
  // Each group has its own drive flop; unselected devices hold the pin released.
  qs_bus_drive #(.W(1)) u_ae_flag (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .next_value  (ae_status_n[next_rd_q]), // [R3] [R8] [R20]
    .next_drive  (next_rd_owned), // [R7]
    .reset_value (1'b1),
    .value       (almost_empty_flag),
    .drive       (almost_empty_flag_oe)
  );

  qs_bus_drive #(.W(1)) u_af_flag (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .next_value  (af_status_n[next_wr_q]), // [R12] [R20]
    .next_drive  (next_wr_owned), // [R13]
    .reset_value (1'b1),
    .value       (almost_full_flag),
    .drive       (almost_full_flag_oe)
  );

  qs_bus_drive #(.W(NUM_Q)) u_ae_bus (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .next_value  (ae_status_n), // [R6] [R8]
    .next_drive  (next_ae_own), // [R4] [R5]
    .reset_value ({NUM_Q{1'b1}}),
    .value       (almost_empty_status_bus),
    .drive       (almost_empty_status_bus_oe)
  );

  qs_bus_drive #(.W(NUM_Q)) u_af_bus (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .next_value  (af_status_n), // [R6] [R9] [R12]
    .next_drive  (next_af_own), // [R10]
    .reset_value ({NUM_Q{1'b1}}),
    .value       (almost_full_status_bus),
    .drive       (almost_full_status_bus_oe)
  );

  // ******************************************************************
  // Expansion outputs
  // ******************************************************************
  // Unused in direct mode; held at a steady idle level from a flop.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      full_expand_out  <= EXPAND_OUT_IDLE;
      empty_expand_out <= EXPAND_OUT_IDLE;
    end else begin
      full_expand_out  <= EXPAND_OUT_IDLE;
      empty_expand_out <= EXPAND_OUT_IDLE;
    end
  end

endmodule

// ==== qs_peer_model.sv ====
// Peer device sharing both status buses.
`timescale 1ns/1ps
module qs_peer_model #(
  parameter logic [qs_pkg::DEV_W-1:0] PEER_ID = 3'h1,
  parameter logic [qs_pkg::NUM_Q-1:0] AE_PAT  = 8'ha5,
  parameter logic [qs_pkg::NUM_Q-1:0] AF_PAT  = 8'h3c
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire qs_pkg::qs_owner_t        ae_bus_sel,
  input  wire qs_pkg::qs_owner_t        af_bus_sel,
  output logic      [qs_pkg::NUM_Q-1:0] ae_bus,
  output logic                          ae_oe,
  output logic      [qs_pkg::NUM_Q-1:0] af_bus,
  output logic                          af_oe
);
  import qs_pkg::*;
  logic next_ae_oe;
  logic next_af_oe;
  // ******************************************************************
  // Bus ownership
  // ******************************************************************
  always_comb begin
    next_ae_oe = ae_oe;
    next_af_oe = af_oe;
    if (ae_bus_sel.valid) begin
      next_ae_oe = (ae_bus_sel.device == PEER_ID);
    end
    if (af_bus_sel.valid) begin
      next_af_oe = (af_bus_sel.device == PEER_ID);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ae_oe <= 1'b0;
      af_oe <= 1'b0;
    end else begin
      ae_oe <= next_ae_oe;
      af_oe <= next_af_oe;
    end
  end
  // A released bus shows the inverse pattern, never a stale value.
  assign ae_bus = ae_oe ? AE_PAT : ~AE_PAT;
  assign af_bus = af_oe ? AF_PAT : ~AF_PAT;
endmodule

// ==== qs_multiqueue_flags_asserts.sv ====
// Checks on the flag, status bus and data ports.
`timescale 1ns/1ps
module qs_multiqueue_flags_asserts #(
  parameter logic [qs_pkg::DEV_W-1:0] DEVICE_ID = 3'h0
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire qs_pkg::qs_select_t        write_sel,
  input  wire logic                      read_en_n,
  input  wire qs_pkg::qs_select_t        read_sel,
  input  wire qs_pkg::qs_owner_t         ae_bus_sel,
  input  wire qs_pkg::qs_owner_t         af_bus_sel,
  input  wire logic                      output_enable_n,
  input  wire logic [qs_pkg::DATA_W-1:0] data_out,
  input  wire logic                      data_out_oe,
  input  wire logic                      almost_empty_flag,
  input  wire logic                      almost_empty_flag_oe,
  input  wire logic                      almost_full_flag,
  input  wire logic                      almost_full_flag_oe,
  input  wire logic [qs_pkg::NUM_Q-1:0]  almost_empty_status_bus,
  input  wire logic                      almost_empty_status_bus_oe,
  input  wire logic [qs_pkg::NUM_Q-1:0]  almost_full_status_bus,
  input  wire logic                      almost_full_status_bus_oe
);
  import qs_pkg::*;
  logic [QW-1:0] rd_q;
  logic [QW-1:0] wr_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ******************************************************************
  // Selected queues
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_q <= '0;
      wr_q <= '0;
    end else begin
      rd_q <= read_sel.valid ? read_sel.queue : rd_q;
      wr_q <= write_sel.valid ? write_sel.queue : wr_q;
    end
  end
  AST_AE_OWN: assert property (ae_bus_sel.valid && ae_bus_sel.device == DEVICE_ID
    |=> almost_empty_status_bus_oe) else $error("ae bus not owned");
  AST_AE_FREE: assert property (ae_bus_sel.valid && ae_bus_sel.device != DEVICE_ID
    |=> !almost_empty_status_bus_oe) else $error("ae bus not freed");
  AST_AF_OWN: assert property (af_bus_sel.valid && af_bus_sel.device == DEVICE_ID
    |=> almost_full_status_bus_oe) else $error("af bus not owned");
  AST_AF_FREE: assert property (af_bus_sel.valid && af_bus_sel.device != DEVICE_ID
    |=> !almost_full_status_bus_oe) else $error("af bus not freed");
  AST_AE_FLOAT: assert property (read_sel.valid && read_sel.device != DEVICE_ID
    |=> !almost_empty_flag_oe) else $error("ae flag driven");
  AST_AF_DRIVE: assert property (write_sel.valid && write_sel.device == DEVICE_ID
    |=> almost_full_flag_oe) else $error("af flag not driven");
  AST_AE_MATCH: assert property (almost_empty_flag_oe && almost_empty_status_bus_oe
    |-> almost_empty_flag == almost_empty_status_bus[rd_q]) else $error("ae flag mismatch");
  AST_AF_MATCH: assert property (almost_full_flag_oe && almost_full_status_bus_oe
    |-> almost_full_flag == almost_full_status_bus[wr_q]) else $error("af flag mismatch");
  AST_DATA_OE: assert property (output_enable_n |=> !data_out_oe)
    else $error("data bus driven");
  AST_DATA_HOLD: assert property ((read_en_n && !read_sel.valid)[*4]
    |=> $stable(data_out)) else $error("data changed");
endmodule
bind qs_multiqueue_flags qs_multiqueue_flags_asserts #(.DEVICE_ID(DEVICE_ID)) i_chk (.*);

// ==== qs_multiqueue_flags_tb.sv ====
// Testbench for the multi-queue flag block.
`timescale 1ns/1ps
module qs_multiqueue_flags_tb;
  import qs_pkg::*;
  logic              ref_clk, reset_n, write_en_n, read_en_n;
  logic [DATA_W-1:0] write_data, data_out;
  qs_select_t        write_sel, read_sel;
  qs_owner_t         ae_bus_sel, af_bus_sel;
  logic              output_enable_n, ae_skew_late, af_skew_late, data_out_oe;
  logic              almost_empty_flag, almost_empty_flag_oe, almost_full_flag;
  logic              almost_full_flag_oe, almost_empty_status_bus_oe, almost_full_status_bus_oe;
  logic              full_expand_out, empty_expand_out, p_ae_oe, p_af_oe;
  logic [NUM_Q-1:0]  almost_empty_status_bus, almost_full_status_bus, p_ae, p_af, ae_w, af_w;
  int                fail_count = 0;
  int                n_tests = 0;
  // Pull-ups hold the shared buses high when undriven.
  assign ae_w = almost_empty_status_bus_oe ? almost_empty_status_bus : p_ae_oe ? p_ae : 8'hff;
  assign af_w = almost_full_status_bus_oe ? almost_full_status_bus : p_af_oe ? p_af : 8'hff;
  qs_multiqueue_flags i_qs_multiqueue_flags (
    .*, .full_expand_in(1'b0), .empty_expand_in(1'b0));
  qs_peer_model i_qs_peer_model (
    .ref_clk(ref_clk), .reset_n(reset_n), .ae_bus_sel(ae_bus_sel), .af_bus_sel(af_bus_sel),
    .ae_bus(p_ae), .ae_oe(p_ae_oe), .af_bus(p_af), .af_oe(p_af_oe));
  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  always #20 ref_clk = ~ref_clk;
  task automatic step(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic sel(input bit rd, input logic [DEV_W-1:0] dev, input logic [QW-1:0] q);
    if (rd) read_sel = '{1'b1, dev, q};
    else write_sel = '{1'b1, dev, q};
    step(1);
    if (rd) read_sel.valid = 1'b0;
    else write_sel.valid = 1'b0;
  endtask
  task automatic own(input bit af, input logic [DEV_W-1:0] dev);
    if (af) af_bus_sel = '{1'b1, dev};
    else ae_bus_sel = '{1'b1, dev};
    step(1);
    if (af) af_bus_sel.valid = 1'b0;
    else ae_bus_sel.valid = 1'b0;
  endtask
  task automatic wr(input int n, input logic [DATA_W-1:0] base);
    write_en_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      write_data = base + DATA_W'(i);
      step(1);
    end
    write_en_n = 1'b1;
  endtask
  // Entered after the taking edge; the flag flips at the lat-th edge.
  task automatic lat_chk(input bit af, input int lat, input int q, input logic v);
    step(lat - 1);
    chk(af ? almost_full_flag : almost_empty_flag, !v);
    step(1);
    chk(af ? almost_full_flag : almost_empty_flag, v);
    chk(af ? af_w[q] : ae_w[q], v);
  endtask
  always @(negedge ref_clk) begin
    if (reset_n) begin
      chk({almost_empty_status_bus_oe & p_ae_oe, almost_full_status_bus_oe & p_af_oe}, 2'h0);
    end
  end
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic test_reset();
    step(2);
    chk({almost_empty_status_bus_oe, almost_full_status_bus_oe}, 2'h3);
    chk({ae_w, af_w}, 16'h00ff);
    chk({full_expand_out, empty_expand_out}, 2'h3);
    $display("test reset done");
  endtask
  task automatic test_empty_rise();
    sel(0, 3'h0, 3'h3);
    sel(1, 3'h0, 3'h3);
    step(3);
    chk({almost_empty_flag_oe, almost_full_flag_oe, data_out_oe}, 3'h7);
    chk({almost_empty_flag, almost_full_flag}, 2'h1);
    wr(3, 36'h100);
    lat_chk(0, int'(FLAG_DEASSERT_LAT), 3, 1'b1);
    chk(ae_w, 8'h08);
    $display("test empty_rise done");
  endtask
  task automatic test_fall_through();
    sel(1, 3'h0, 3'h3);
    step(2);
    chk(data_out, 36'h100);
    lat_chk(0, int'(FLAG_ASSERT_LAT), 3, 1'b0);
    step(3);
    chk(data_out, 36'h100);
    output_enable_n = 1'b1;
    step(1);
    chk(data_out_oe, 1'b0);
    output_enable_n = 1'b0;
    step(1);
    chk({data_out_oe, data_out}, {1'b1, 36'h100});
    $display("test fall_through done");
  endtask
  task automatic test_skew_late();
    ae_skew_late = 1'b1;
    wr(1, 36'h103);
    lat_chk(0, int'(FLAG_DEASSERT_LAT) + 1, 3, 1'b1);
    ae_skew_late = 1'b0;
    read_en_n = 1'b0;
    step(1);
    read_en_n = 1'b1;
    lat_chk(0, int'(FLAG_ASSERT_LAT), 3, 1'b0);
    chk(data_out, 36'h101);
    $display("test skew_late done");
  endtask
  task automatic test_full();
    sel(0, 3'h0, 3'h5);
    wr(13, 36'h200);
    step(3);
    chk(almost_full_flag, 1'b1);
    wr(1, 36'h20d);
    lat_chk(1, int'(FLAG_ASSERT_LAT), 5, 1'b0);
    af_skew_late = 1'b1;
    sel(1, 3'h0, 3'h5);
    step(2);
    lat_chk(1, int'(FLAG_DEASSERT_LAT) + 1, 5, 1'b1);
    af_skew_late = 1'b0;
    chk(data_out, 36'h200);
    $display("test full done");
  endtask
  task automatic test_owner();
    own(0, 3'h1);
    chk({almost_empty_status_bus_oe, ae_w}, {1'b0, 8'ha5});
    own(1, 3'h1);
    chk({almost_full_status_bus_oe, af_w}, {1'b0, 8'h3c});
    own(0, 3'h0);
    chk({almost_empty_status_bus_oe, ae_w}, {1'b1, 8'h20});
    own(1, 3'h0);
    chk({almost_full_status_bus_oe, af_w}, {1'b1, 8'hff});
    sel(1, 3'h2, 3'h0);
    chk(almost_empty_flag_oe, 1'b0);
    step(1);
    sel(0, 3'h2, 3'h0);
    chk(almost_full_flag_oe, 1'b0);
    step(1);
    sel(0, 3'h0, 3'h5);
    chk({almost_full_flag_oe, almost_full_flag}, 2'h3);
    $display("test owner done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {ref_clk, reset_n, write_en_n, read_en_n, output_enable_n} = 5'h06;
    {write_data, write_sel, read_sel, ae_bus_sel, af_bus_sel, ae_skew_late, af_skew_late} = '0;
    step(8);
    reset_n = 1'b1;
    test_reset();
    test_empty_rise();
    test_fall_through();
    test_skew_late();
    test_full();
    test_owner();
    give_verdict();
  end
  // Scenarios take about 70 cycles; a hang stops far beyond.
  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule
